// ==== ctm_top.sv ====
// top of the compact timer: ahb-lite register slave, clock select, flags
// assumes: single-word ahb-lite transfers on mclk, hready from hreadyout
`timescale 1ns/100ps
// Summary of operation
// - compare mode: output level bit sets pin level before first A match
// - PWM mode: output level bit picks active low or active high
// - timer/counter mode: output level and invert bits have no effect
// - invert bit set drives pin inverted, clear drives it straight
// - swap bit 0: P is period, A duty; 1: the reverse
// - clear source 1 clears on A match; 0 on P match or overflow
// - with P clear source, overflow clear only when P value is zero
// - PWM mode ignores clear source; the chosen period clears counter
// - mode field: 00 compare, 10 PWM, 11 timer/counter
// - compare mode with P clear source raises both A and P flags
// - A clear source raises only A flag, never P flag
// - A clear source with A zero overflows at max, no A flag
// - compare mode: pin changes only on A match, not P
// - on A match pin action sets high, low, toggles or holds
// - compare mode: counter on rising edge returns pin to initial level
// - timer/counter mode behaves as compare mode but leaves pin undriven
// - PWM mode raises separate A and P match flags
// - PWM pin action passes waveform or forces inactive or active level
// - swap 0: period is P times 128, or 1024 when zero; duty A
// - duty at or above period gives 100 percent duty
// - swap 1: period is A; duty P times 128, or 1024
// - P compares top three counter bits, A all ten bits
// - counter on rising edge zeroes counter; off keeps residual count
// - pause freezes the counter; release resumes from held value
// - clock select: 000 sys/4, 001 sys, 110 pin rise, 111 pin fall
module ctm_top
  import ctm_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic external_clock_pin,
  output logic timer_output_pin,
  output logic timer_output_pin_oe
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] ctrl0_q;
  logic [7:0] ctrl1_q;
  logic [9:0] cmpa_q;
  logic match_a_flag_q;
  logic match_p_flag_q;
  ctm_aph_s aph_q;
  ctm_bus_e bus_q;
  logic [31:0] rdata_q;
  logic [2:0] ext_sync_q;
  logic ext_lvl_q;
  logic [1:0] div_q;
  logic tick;
  logic match_a;
  logic match_p;
  logic [9:0] cnt;
  logic pin;
  logic pin_oe;
  ctm_cfg_s cfg;
  logic wr_en;

  function automatic logic sel_reg(input logic [11:0] a, input logic [11:0] ofs);
    sel_reg = (a[11:2] == ofs[11:2]);
  endfunction

  assign cfg.on = ctrl0_q[CTM_ON_BIT];
  assign cfg.pause = ctrl0_q[CTM_PAUSE_BIT];
  assign cfg.ck_sel = ctrl0_q[CTM_CKSEL_LSB +: 3];
  assign cfg.rp = ctrl0_q[CTM_RP_LSB +: 3];
  assign cfg.mode = ctrl1_q[CTM_MODE_LSB +: 2];
  assign cfg.io = ctrl1_q[CTM_IO_LSB +: 2];
  assign cfg.oc = ctrl1_q[CTM_OC_BIT];
  assign cfg.pol = ctrl1_q[CTM_POL_BIT];
  assign cfg.dpx = ctrl1_q[CTM_DPX_BIT];
  assign cfg.cclr = ctrl1_q[CTM_CCLR_BIT];
  assign cfg.cmpa = cmpa_q;

  // ---------------------------------------------------------------
  // ahb-lite slave, zero wait states
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      aph_q <= '0;
      bus_q <= CTM_BUS_IDLE;
    end else if (hready) begin
      aph_q.valid <= hsel & htrans[1];
      aph_q.write <= hwrite;
      aph_q.addr <= haddr;
      bus_q <= (hsel & htrans[1]) ? CTM_BUS_DATA : CTM_BUS_IDLE;
    end
  end

  assign wr_en = aph_q.valid & aph_q.write & (bus_q == CTM_BUS_DATA);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // read data registered at the address phase
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (1'b1)
        sel_reg(haddr, CTM_CTRL0_OFS): rdata_q <= {24'h000000, ctrl0_q};
        sel_reg(haddr, CTM_CTRL1_OFS): rdata_q <= {24'h000000, ctrl1_q};
        sel_reg(haddr, CTM_CNT_OFS): rdata_q <= {22'h000000, cnt};
        sel_reg(haddr, CTM_CMPA_OFS): rdata_q <= {22'h000000, cmpa_q};
        sel_reg(haddr, CTM_FLAG_OFS): rdata_q <= {30'h00000000, match_p_flag_q, match_a_flag_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign hrdata = rdata_q;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl0_q <= CTM_CTRL0_RST;
      ctrl1_q <= CTM_CTRL1_RST;
      cmpa_q <= CTM_CMPA_RST;
    end else if (wr_en) begin
      if (sel_reg(aph_q.addr, CTM_CTRL0_OFS)) ctrl0_q <= hwdata[7:0];
      if (sel_reg(aph_q.addr, CTM_CTRL1_OFS)) ctrl1_q <= hwdata[7:0];
      if (sel_reg(aph_q.addr, CTM_CMPA_OFS)) cmpa_q <= hwdata[9:0];
    end
  end

  // ---------------------------------------------------------------
  // match flags, write one to clear, set wins
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      match_a_flag_q <= 1'b0;
      match_p_flag_q <= 1'b0;
    end else begin
      if (match_a) begin
        match_a_flag_q <= 1'b1;
      end else if (wr_en && sel_reg(aph_q.addr, CTM_FLAG_OFS) && hwdata[CTM_AF_BIT]) begin
        match_a_flag_q <= 1'b0;
      end
      if (match_p) begin
        match_p_flag_q <= 1'b1;
      end else if (wr_en && sel_reg(aph_q.addr, CTM_FLAG_OFS) && hwdata[CTM_PF_BIT]) begin
        match_p_flag_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // counter clock select
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ext_sync_q <= 3'h0;
      ext_lvl_q <= 1'b0;
      div_q <= 2'h0;
    end else begin
      ext_sync_q <= {ext_sync_q[1:0], external_clock_pin};
      if (ext_sync_q[2] == ext_sync_q[1]) begin
        ext_lvl_q <= ext_sync_q[2];
      end
      div_q <= (div_q == 2'(CTM_DIV4 - 1)) ? 2'h0 : div_q + 2'h1;
    end
  end

  always_comb begin
    case (cfg.ck_sel)
      CTM_CK_DIV4: tick = (div_q == 2'(CTM_DIV4 - 1));
      CTM_CK_SYS: tick = 1'b1;
      CTM_CK_PIN_RISE: tick = (ext_sync_q[2] == ext_sync_q[1]) & ext_sync_q[2] & ~ext_lvl_q;
      CTM_CK_PIN_FALL: tick = (ext_sync_q[2] == ext_sync_q[1]) & ~ext_sync_q[2] & ext_lvl_q;
      default: tick = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // counter core
  // ---------------------------------------------------------------
  ctm_core #(
    .CNT_W(10)
  ) u_core (
    .mclk(mclk),
    .rst_n(rst_n),
    .cfg(cfg),
    .tick(tick),
    .match_a(match_a),
    .match_p(match_p),
    .cnt_q(cnt),
    .pin_q(pin),
    .pin_oe_q(pin_oe)
  );

  assign timer_output_pin = pin;
  assign timer_output_pin_oe = pin_oe;

endmodule // ctm_top

// ==== ctm_pkg.sv ====
// package: register map, field positions, reset values and types of the compact timer
// assumes: included by every design file of the compact timer
package ctm_pkg;

  // register byte addresses
  localparam logic [11:0] CTM_CTRL0_OFS = 12'h000;
  localparam logic [11:0] CTM_CTRL1_OFS = 12'h004;
  localparam logic [11:0] CTM_CNT_OFS = 12'h008;
  localparam logic [11:0] CTM_CMPA_OFS = 12'h00C;
  localparam logic [11:0] CTM_FLAG_OFS = 12'h010;

  // control 0 fields
  localparam int CTM_PAUSE_BIT = 7;
  localparam int CTM_CKSEL_LSB = 4;
  localparam int CTM_ON_BIT = 3;
  localparam int CTM_RP_LSB = 0;

  // control 1 fields
  localparam int CTM_MODE_LSB = 6;
  localparam int CTM_IO_LSB = 4;
  localparam int CTM_OC_BIT = 3;
  localparam int CTM_POL_BIT = 2;
  localparam int CTM_DPX_BIT = 1;
  localparam int CTM_CCLR_BIT = 0;

  // flag register fields
  localparam int CTM_AF_BIT = 0;
  localparam int CTM_PF_BIT = 1;

  // reset values
  localparam logic [7:0] CTM_CTRL0_RST = 8'h00;
  localparam logic [7:0] CTM_CTRL1_RST = 8'h00;
  localparam logic [9:0] CTM_CMPA_RST = 10'h000;

  // divide ratio of the slow internal clock
  localparam int CTM_DIV4 = 4;

  // mode and clock encodings
  localparam logic [1:0] CTM_MODE_CMP = 2'h0;
  localparam logic [1:0] CTM_MODE_PWM = 2'h2;
  localparam logic [1:0] CTM_MODE_TMR = 2'h3;
  localparam logic [2:0] CTM_CK_DIV4 = 3'h0;
  localparam logic [2:0] CTM_CK_SYS = 3'h1;
  localparam logic [2:0] CTM_CK_PIN_RISE = 3'h6;
  localparam logic [2:0] CTM_CK_PIN_FALL = 3'h7;

  typedef enum {CTM_BUS_IDLE, CTM_BUS_DATA} ctm_bus_e;

  // latched address phase of an ahb transfer
  typedef struct packed {
    logic valid;
    logic write;
    logic [11:0] addr;
  } ctm_aph_s;

  // control settings handed to the counter core
  typedef struct packed {
    logic on;
    logic pause;
    logic [2:0] ck_sel;
    logic [2:0] rp;
    logic [1:0] mode;
    logic [1:0] io;
    logic oc;
    logic pol;
    logic dpx;
    logic cclr;
    logic [9:0] cmpa;
  } ctm_cfg_s;

endpackage

// ==== ctm_core.sv ====
// counter, comparators and pin logic of the compact timer
// assumes: configuration from the register slave, tick on mclk
`timescale 1ns/100ps
module ctm_core
  import ctm_pkg::*;
#(
  parameter int CNT_W = 10
) (
  input wire logic mclk,
  input wire logic rst_n,
  input ctm_cfg_s cfg,
  input wire logic tick,
  output logic match_a,
  output logic match_p,
  output logic [CNT_W-1:0] cnt_q,
  output logic pin_q,
  output logic pin_oe_q
);

  logic on_q;
  logic on_rise;
  logic [2:0] cnt_top;
  logic cnt_max;
  logic p_hit;
  logic a_hit;
  logic is_pwm;
  logic is_cmp;
  logic clr;
  logic pwm_act;
  logic [CNT_W:0] per_val;
  logic [CNT_W:0] duty_val;
  logic [CNT_W:0] p_scaled;
  logic pin_lvl_q;
  logic per_a;
  logic per_p;

  assign on_rise = cfg.on & ~on_q;
  assign cnt_top = cnt_q[CNT_W-1:CNT_W-3];
  assign cnt_max = &cnt_q;
  assign p_hit = (cfg.rp != 3'h0) && (cnt_top == cfg.rp) && (cnt_q[CNT_W-4:0] == '0);
  assign a_hit = (cfg.cmpa != '0) && (cnt_q == cfg.cmpa);
  assign is_pwm = (cfg.mode == CTM_MODE_PWM);
  assign is_cmp = (cfg.mode == CTM_MODE_CMP);

  // compare p scaled to counter clocks; zero means full range
  assign p_scaled = (cfg.rp == 3'h0) ? (CNT_W+1)'(1 << CNT_W) : (CNT_W+1)'({cfg.rp, 7'h00});
  assign per_val = cfg.dpx ? {1'b0, cfg.cmpa} : p_scaled;
  assign duty_val = cfg.dpx ? p_scaled : {1'b0, cfg.cmpa};

  // ---------------------------------------------------------------
  // clear condition
  // ---------------------------------------------------------------
  always_comb begin
    if (is_pwm) begin
      clr = ({1'b0, cnt_q} + (CNT_W+1)'(1)) >= per_val;
    end else if (cfg.cclr) begin
      clr = a_hit | cnt_max;
    end else begin
      clr = p_hit | ((cfg.rp == 3'h0) & cnt_max);
    end
  end

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      on_q <= 1'b0;
    end else begin
      on_q <= cfg.on;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (on_rise) begin
      cnt_q <= '0;
    end else if (cfg.on && !cfg.pause && tick) begin
      cnt_q <= clr ? '0 : cnt_q + 1'b1;
    end
  end

  // pwm period end is the match of whichever comparator sets the period
  assign per_a = is_pwm & cfg.dpx & clr & (cfg.cmpa != '0);
  assign per_p = is_pwm & ~cfg.dpx & clr & (cfg.rp != 3'h0);

  // match events, one per counter tick
  always_comb begin
    match_a = 1'b0;
    match_p = 1'b0;
    if (cfg.on && !cfg.pause && tick && !on_rise) begin
      match_a = a_hit | per_a;
      match_p = (p_hit & (is_pwm | ~cfg.cclr)) | per_p;
    end
  end

  // ---------------------------------------------------------------
  // output pin
  // ---------------------------------------------------------------
  assign pwm_act = ({1'b0, cnt_q} < duty_val) || (duty_val >= per_val);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pin_lvl_q <= 1'b0;
    end else if (is_cmp && on_rise) begin
      pin_lvl_q <= cfg.oc;
    end else if (is_cmp && match_a) begin
      case (cfg.io)
        2'h1: pin_lvl_q <= 1'b0;
        2'h2: pin_lvl_q <= 1'b1;
        2'h3: pin_lvl_q <= ~pin_lvl_q;
        default: pin_lvl_q <= pin_lvl_q;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pin_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end else begin
      pin_oe_q <= (cfg.mode != CTM_MODE_TMR);
      if (is_pwm) begin
        case (cfg.io)
          2'h0: pin_q <= ~cfg.oc ^ cfg.pol;
          2'h1: pin_q <= cfg.oc ^ cfg.pol;
          2'h2: pin_q <= (pwm_act ~^ cfg.oc) ^ cfg.pol;
          default: pin_q <= ~cfg.oc ^ cfg.pol;
        endcase
      end else begin
        pin_q <= pin_lvl_q ^ cfg.pol;
      end
    end
  end

endmodule // ctm_core

// ==== ctm_properties.sv ====
// checker: bus answer, readback and pin level properties
// assumes: bound into ctm_top, clock mclk, sync reset rst_n
`timescale 1ns/100ps
module ctm_properties
  import ctm_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic external_clock_pin,
  input wire logic timer_output_pin,
  input wire logic timer_output_pin_oe
);
  // ----
  // control register shadow
  // ----
  logic wr_q;
  logic [9:0] wa_q;
  logic [7:0] c0_q;
  logic [7:0] c1_q;
  logic [1:0] age_q;
  logic hit;
  assign hit = hsel && htrans[1] && hready;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wr_q <= 1'b0;
      wa_q <= 10'h000;
    end else if (hready) begin
      wr_q <= hit && hwrite;
      wa_q <= haddr[11:2];
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      c0_q <= 8'h00;
      c1_q <= 8'h00;
    end else if (wr_q && wa_q == 10'h000) begin
      c0_q <= hwdata[7:0];
    end else if (wr_q && wa_q == 10'h001) begin
      c1_q <= hwdata[7:0];
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      age_q <= 2'h0;
    end else if (wr_q && wa_q[9:1] == 9'h000) begin
      age_q <= 2'h0;
    end else if (age_q != 2'h3) begin
      age_q <= age_q + 2'h1;
    end
  end
  // ----
  // properties
  // ----
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  sequence s_rd(a);
    hit && !hwrite && haddr[11:2] == a;
  endsequence
  sequence s_on_rise;
    $rose(c0_q[3]) && c1_q[7:6] == 2'h0;
  endsequence
  a_ready_high: assert property (hreadyout) else $error("hreadyout low");
  a_resp_okay: assert property (!hresp) else $error("hresp not okay");
  a_unmapped_zero: assert property (hit && !hwrite && haddr[11:2] > 10'h004 |=> hrdata == 0)
    else $error("unmapped read not zero");
  a_ctrl0_back: assert property (s_rd(10'h000) |=> hrdata == {24'h0, $past(c0_q)})
    else $error("control 0 readback wrong");
  a_ctrl1_back: assert property (s_rd(10'h001) |=> hrdata == {24'h0, $past(c1_q)})
    else $error("control 1 readback wrong");
  a_oe_by_mode: assert property ($past(rst_n) |-> timer_output_pin_oe ==
    ($past(c1_q[7:6]) != 2'h3)) else $error("pin enable wrong for mode");
  a_on_rise_level: assert property (s_on_rise |-> ##2 timer_output_pin == (c1_q[3] ^ c1_q[2]))
    else $error("pin not at initial level");
  a_hold_no_action: assert property (age_q == 2'h3 && c1_q[7:4] == 4'h0
    |-> $stable(timer_output_pin)) else $error("pin moved with no action");
  a_pwm_forced: assert property (age_q == 2'h3 && c1_q[7:5] == 3'h4
    |-> timer_output_pin == (c1_q[3] ^ c1_q[2] ^ !c1_q[4])) else $error("forced level wrong");
endmodule // ctm_properties
bind ctm_top ctm_properties i_ctm_properties (
  .mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .external_clock_pin(external_clock_pin), .timer_output_pin(timer_output_pin),
  .timer_output_pin_oe(timer_output_pin_oe)
);

// ==== compact_timer_compare_pwm_tb_top.sv ====
// testbench: registers, count clocks, flags and pin waveforms
// assumes: ctm_top alone, bus master and pin stimulus here
`timescale 1ns/100ps
module compact_timer_compare_pwm_tb_top
  import ctm_pkg::*;
;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic ext_pin = 1'b0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic pin;
  logic pin_oe;
  logic [31:0] rd_a;
  logic [31:0] rd_b;
  int err_count = 0;
  int checks_done = 0;
  ctm_top i_ctm_top (
    .mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .external_clock_pin(ext_pin),
    .timer_output_pin(pin), .timer_output_pin_oe(pin_oe)
  );
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  // ----
  // bus and compare tasks
  // ----
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    rd_b = hrdata;
    if (w) @(posedge mclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_regs();
    for (int i = 0; i < 6; i++) begin
      rd(12'(4 * i));
      chk("reset value", rd_b, 32'h0);
    end
    wr(12'h020, 32'hFF);
    rd(12'h020);
    chk("unmapped", rd_b, 32'h0);
    wr(12'h004, 32'h3B);
    rd(12'h004);
    chk("control 1", rd_b, 32'h3B);
    wr(12'h008, 32'h155);
    rd(12'h008);
    chk("counter read only", rd_b, 32'h0);
    wr(12'h004, 32'h0);
    $display("t_regs done");
  endtask
  task automatic t_clk();
    logic [2:0] ck [5];
    int ex [5];
    ck = '{3'h1, 3'h0, 3'h6, 3'h7, 3'h2};
    ex = '{24, 6, 4, 4, 0};
    for (int i = 0; i < 5; i++) begin
      wr(12'h000, 32'h0);
      wr(12'h000, {25'h0, ck[i], 4'h8});
      rd(12'h008);
      rd_a = rd_b;
      repeat (4) begin
        ext_pin <= 1'b1;
        cyc(2);
        ext_pin <= 1'b0;
        cyc(2);
      end
      cyc(6);
      rd(12'h008);
      chk("count step", rd_b - rd_a, 32'(ex[i]));
    end
    $display("t_clk done");
  endtask
  task automatic t_hold();
    wr(12'h000, 32'h98);
    rd(12'h008);
    rd_a = rd_b;
    cyc(10);
    rd(12'h008);
    chk("paused", rd_b, rd_a);
    wr(12'h000, 32'h18);
    cyc(40);
    rd(12'h008);
    chk("resumed", 32'(rd_b > rd_a), 32'h1);
    wr(12'h000, 32'h10);
    rd(12'h008);
    rd_a = rd_b;
    cyc(10);
    rd(12'h008);
    chk("stopped", rd_b, rd_a);
    wr(12'h000, 32'h18);
    rd(12'h008);
    chk("cleared", 32'(rd_b < 8), 32'h1);
    $display("t_hold done");
  endtask
  task automatic t_flags();
    logic [7:0] m;
    for (int i = 0; i < 2; i++) begin
      m = i ? 8'hC0 : 8'h00;
      wr(12'h000, 32'h0);
      wr(12'h004, {24'h0, m});
      wr(12'h00C, 32'h32);
      wr(12'h010, 32'h3);
      wr(12'h000, 32'h19);
      cyc(140);
      rd(12'h010);
      chk("flags p clear", rd_b, 32'h3);
      chk("pin enable", 32'(pin_oe), 32'(i == 0));
      wr(12'h010, 32'h3);
      rd(12'h010);
      chk("flags cleared", rd_b, 32'h0);
      wr(12'h004, {24'h0, m | 8'h01});
      wr(12'h00C, 32'h12C);
      wr(12'h010, 32'h3);
      cyc(400);
      rd(12'h010);
      chk("flags a clear", rd_b, 32'h1);
      wr(12'h00C, 32'h0);
      wr(12'h010, 32'h3);
      cyc(1100);
      rd(12'h010);
      chk("flags a zero", rd_b, 32'h0);
    end
    $display("t_flags done");
  endtask
  task automatic t_cmp_pin();
    logic [1:0] io;
    logic oc;
    logic pol;
    logic lv;
    for (int i = 0; i < 8; i++) begin
      io = i[1:0];
      oc = i[2];
      pol = i[0] ^ i[2];
      lv = io == 2'h0 ? oc : io == 2'h1 ? 1'b0 : io == 2'h2 ? 1'b1 : !oc;
      wr(12'h000, 32'h0);
      wr(12'h004, {26'h0, io, oc, pol, 2'h0});
      wr(12'h00C, 32'h28);
      wr(12'h000, 32'h19);
      cyc(2);
      chk("initial level", 32'(pin), 32'(oc ^ pol));
      cyc(148);
      chk("after match", 32'(pin), 32'(lv ^ pol));
    end
    $display("t_cmp_pin done");
  endtask
  task automatic t_pwm();
    logic [7:0] c1 [9];
    logic [2:0] rp [9];
    logic [9:0] ca [9];
    int win [9];
    int exh [9];
    int n;
    c1 = '{8'hA8, 8'hA0, 8'hAC, 8'hA8, 8'hAA, 8'h98, 8'h88, 8'hB8, 8'hA9};
    rp = '{3'h1, 3'h1, 3'h1, 3'h2, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1};
    ca = '{10'h020, 10'h020, 10'h020, 10'h12C, 10'h200, 10'h020, 10'h020, 10'h020, 10'h020};
    win = '{128, 128, 128, 256, 512, 128, 128, 128, 128};
    exh = '{32, 96, 96, 256, 128, 128, 0, 0, 32};
    for (int i = 0; i < 9; i++) begin
      wr(12'h000, 32'h0);
      wr(12'h004, {24'h0, c1[i]});
      wr(12'h00C, {22'h0, ca[i]});
      wr(12'h000, {29'h3, rp[i]});
      cyc(20);
      n = 0;
      repeat (win[i]) begin
        @(posedge mclk);
        if (pin === 1'b1)
          n++;
      end
      chk("active count", 32'(n), 32'(exh[i]));
    end
    wr(12'h010, 32'h3);
    cyc(150);
    rd(12'h010);
    chk("pwm flags", rd_b, 32'h3);
    $display("t_pwm done");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    t_regs();
    t_clk();
    t_hold();
    t_flags();
    t_cmp_pin();
    t_pwm();
    summarize();
  end
  initial begin
    repeat (40000) @(posedge mclk);
    err_count++;
    $display("watchdog expired");
    summarize();
  end
endmodule // compact_timer_compare_pwm_tb_top
